/* common/qdac_pkg.sv */
// shared constants and types for the quad dac update control
package qdac_pkg;

    localparam int unsigned NUM_CH      = 4;
    localparam int unsigned CODE_W      = 16;
    localparam int unsigned FRAME_BITS  = 24;
    localparam int unsigned CNT_W       = 5;

    // word layout: command, channel select, code
    localparam int unsigned CMD_HI      = 23;
    localparam int unsigned CMD_LO      = 20;
    localparam int unsigned ADDR_HI     = 19;
    localparam int unsigned ADDR_LO     = 16;
    localparam int unsigned DATA_HI     = 15;
    localparam int unsigned DATA_LO     = 0;
    localparam int unsigned MASK_HI     = 3;
    localparam int unsigned MASK_LO     = 0;

    // command codes
    localparam logic [3:0] CMD_WR_INPUT  = 4'h1;
    localparam logic [3:0] CMD_UPDATE    = 4'h2;
    localparam logic [3:0] CMD_WR_UPDATE = 4'h3;
    localparam logic [3:0] CMD_LOAD_MASK = 4'h5;
    localparam logic [3:0] CMD_SW_RESET  = 4'h6;

    // reset values and clear codes
    localparam logic [3:0]  MASK_RESET   = 4'h0;
    localparam logic [15:0] CODE_ZERO    = 16'h0000;
    localparam logic [15:0] CODE_MID     = 16'h8000;
    localparam logic [23:0] SHIFT_RESET  = 24'h00_0000;
    localparam logic [4:0]  CNT_RESET    = 5'h00;
    localparam logic [4:0]  CNT_MAX      = 5'h1f;
    localparam logic [4:0]  CNT_FRAME    = 5'h18;

    // reset pin timing at the 10 MHz reference
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned RST_MIN_NS     = 30;
    localparam int unsigned RST_MIN_CYC_RAW =
        (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RST_MIN_CYC =
        (RST_MIN_CYC_RAW < 1) ? 1 : RST_MIN_CYC_RAW;

    typedef enum logic [1:0] {
        QDAC_INIT  = 2'b00,
        QDAC_RUN   = 2'b01,
        QDAC_HWRST = 2'b11
    } qdac_mode_e;

    typedef logic [NUM_CH-1:0][CODE_W-1:0] qdac_codes_t;

    typedef struct packed {
        logic sclk;
        logic sdin;
        logic sync_n;
    } qdac_serial_s;

    typedef struct packed {
        logic load_strobe_n;
        logic hw_reset_n;
        logic reset_level_select;
    } qdac_pins_s;

    typedef struct packed {
        qdac_mode_e            mode;
        logic [2:0]            sclk_sy;
        logic [2:0]            sync_sy;
        logic [1:0]            sdin_sy;
        logic [2:0]            load_sy;
        logic [1:0]            hrst_sy;
        logic [FRAME_BITS-1:0] shift;
        logic [CNT_W-1:0]      cnt;
        logic [NUM_CH-1:0]     mask;
        qdac_codes_t           in_code;
        qdac_codes_t           dac_code;
    } qdac_state_s;

endpackage : qdac_pkg

/* design/qdac_update_ctrl.sv */
// quad dac serial command decode, load-pin masking and reset handling
//
// Operation
// - load-mask command copies data bits 3..0 into mask, address ignored
// - every mask bit is zero after power-on or software reset
// - masked channel ignores load pin falling edge, sees it as high
// - write-input always loads input; dac too only if load pin low
// - update command copies input to dac for addressed channels
// - write-and-update loads input and dac, load pin ignored
// - falling load edge copies input to dac on unmasked channels
// - load pin held low overrides the mask bits
// - hardware reset low clears outputs to zero or midscale by select
// - after reset release outputs keep cleared code until reprogrammed
// - no output update while hardware reset is low
// - software reset command restores the power-on code
// - load pin activity during power-on reset is ignored
// - hardware reset low at power-up delays initialization until release
// - power-up code is zero with select low, midscale with select high
// - outputs keep power-up code until a valid write arrives
// - transfers are 24-bit words latched on frame-sync rising edge
// - load low during write-input updates both registers at frame end
// - load high during write defers dac update to later load fall
// - top four bits are command, next four select channels
`timescale 1ns/1ps

module qdac_update_ctrl (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // serial command port
    input  wire qdac_pkg::qdac_serial_s serial,
    // control pins
    input  wire qdac_pkg::qdac_pins_s pins,
    // channel codes and status
    output qdac_pkg::qdac_codes_t     dac_code,
    output qdac_pkg::qdac_codes_t     input_code,
    output logic [3:0]                load_mask,
    output qdac_pkg::qdac_mode_e      mode
);
    import qdac_pkg::*;

    qdac_state_s st_reg;
    qdac_state_s st_next;

    // decoded frame view
    logic        sclk_fall;
    logic        sync_rise;
    logic        sync_fall;
    logic        load_fall;
    logic        load_low;
    logic        hrst_low;
    logic        frame_ok;
    logic [3:0]  cmd;
    logic [3:0]  addr;
    logic [15:0] data;

    function automatic logic [15:0] clear_code(input logic sel);
        return sel ? CODE_MID : CODE_ZERO;
    endfunction : clear_code

    function automatic qdac_codes_t fill_codes(input logic [15:0] c);
        qdac_codes_t r;
        for (int i = 0; i < NUM_CH; i++) begin
            r[i] = c;
        end
        return r;
    endfunction : fill_codes

    // edges and levels from synced pins
    // only stage 1 and 2 of each synchroniser are looked at
    assign sclk_fall = st_reg.sclk_sy[2] & ~st_reg.sclk_sy[1];
    assign sync_rise = ~st_reg.sync_sy[2] & st_reg.sync_sy[1];
    assign sync_fall = st_reg.sync_sy[2] & ~st_reg.sync_sy[1];
    assign load_fall = st_reg.load_sy[2] & ~st_reg.load_sy[1];
    assign load_low  = ~st_reg.load_sy[1];
    assign hrst_low  = ~st_reg.hrst_sy[1];

    // frame taken on sync rise
    // short or long frames are dropped rather than half-decoded
    assign frame_ok = sync_rise && (st_reg.cnt == CNT_FRAME);

    assign cmd  = st_reg.shift[CMD_HI:CMD_LO];
    assign addr = st_reg.shift[ADDR_HI:ADDR_LO];
    assign data = st_reg.shift[DATA_HI:DATA_LO];

    always_comb begin
        st_next = st_reg;

        st_next.sclk_sy = {st_reg.sclk_sy[1:0], serial.sclk};
        st_next.sync_sy = {st_reg.sync_sy[1:0], serial.sync_n};
        st_next.sdin_sy = {st_reg.sdin_sy[0], serial.sdin};
        st_next.load_sy = {st_reg.load_sy[1:0], pins.load_strobe_n};
        st_next.hrst_sy = {st_reg.hrst_sy[0], pins.hw_reset_n};

        // shift in on sclk fall while frame is open
        if (sync_fall) begin
            st_next.cnt = CNT_RESET;
        end else if (!st_reg.sync_sy[1] && sclk_fall) begin
            st_next.shift = {st_reg.shift[FRAME_BITS-2:0],
                             st_reg.sdin_sy[1]};
            if (st_reg.cnt != CNT_MAX) begin
                st_next.cnt = st_reg.cnt + CNT_W'(1);
            end
        end

        case (st_reg.mode)
            QDAC_INIT: begin
                // load edges are not acted on here
                if (!hrst_low) begin
                    st_next.in_code =
                        fill_codes(clear_code(pins.reset_level_select));
                    st_next.dac_code =
                        fill_codes(clear_code(pins.reset_level_select));
                    st_next.mask = MASK_RESET;
                    st_next.mode = QDAC_RUN;
                end
            end
            QDAC_RUN: begin
                if (hrst_low) begin
                    st_next.in_code =
                        fill_codes(clear_code(pins.reset_level_select));
                    st_next.dac_code =
                        fill_codes(clear_code(pins.reset_level_select));
                    st_next.mode = QDAC_HWRST;
                end else begin
                    // masked channels see the pin as high
                    if (load_fall) begin
                        for (int i = 0; i < NUM_CH; i++) begin
                            if (!st_reg.mask[i]) begin
                                st_next.dac_code[i] = st_reg.in_code[i];
                            end
                        end
                    end
                    // frame commands take effect only on a valid frame
                    if (frame_ok) begin
                        case (cmd)
                            CMD_WR_INPUT: begin
                                for (int i = 0; i < NUM_CH; i++) begin
                                    if (addr[i]) begin
                                        st_next.in_code[i] = data;
                                        if (load_low) begin
                                            st_next.dac_code[i] = data;
                                        end
                                    end
                                end
                            end
                            CMD_UPDATE: begin
                                for (int i = 0; i < NUM_CH; i++) begin
                                    if (addr[i]) begin
                                        st_next.dac_code[i] =
                                            st_reg.in_code[i];
                                    end
                                end
                            end
                            CMD_WR_UPDATE: begin
                                for (int i = 0; i < NUM_CH; i++) begin
                                    if (addr[i]) begin
                                        st_next.in_code[i] = data;
                                        st_next.dac_code[i] = data;
                                    end
                                end
                            end
                            CMD_LOAD_MASK: begin
                                st_next.mask = st_reg.shift[MASK_HI:MASK_LO];
                            end
                            CMD_SW_RESET: begin
                                st_next.in_code = fill_codes(
                                    clear_code(pins.reset_level_select));
                                st_next.dac_code = fill_codes(
                                    clear_code(pins.reset_level_select));
                                st_next.mask = MASK_RESET;
                            end
                            default: begin
                                // unsupported commands are dropped
                                st_next.mask = st_reg.mask;
                            end
                        endcase
                    end
                end
            end
            QDAC_HWRST: begin
                // hold cleared code, frames and load ignored
                st_next.in_code =
                    fill_codes(clear_code(pins.reset_level_select));
                st_next.dac_code =
                    fill_codes(clear_code(pins.reset_level_select));
                if (!hrst_low) begin
                    st_next.mode = QDAC_RUN;
                end
            end
            default: begin
                st_next.mode = QDAC_INIT;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_reg.mode     <= QDAC_INIT;
            st_reg.sclk_sy  <= 3'b000;
            st_reg.sync_sy  <= 3'b111;
            st_reg.sdin_sy  <= 2'b00;
            st_reg.load_sy  <= 3'b111;
            st_reg.hrst_sy  <= 2'b00;
            st_reg.shift    <= SHIFT_RESET;
            st_reg.cnt      <= CNT_RESET;
            st_reg.mask     <= MASK_RESET;
            st_reg.in_code  <= fill_codes(CODE_ZERO);
            st_reg.dac_code <= fill_codes(CODE_ZERO);
        end else begin
            st_reg <= st_next;
        end
    end

    assign dac_code   = st_reg.dac_code;
    assign input_code = st_reg.in_code;
    assign load_mask  = st_reg.mask;
    assign mode       = st_reg.mode;

    a_mask_load_cmd: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (st_reg.mode == QDAC_RUN && !hrst_low && frame_ok
            && cmd == CMD_LOAD_MASK)
        |=> load_mask == $past(st_reg.shift[MASK_HI:MASK_LO]))
        else $error("mask not loaded from frame");

    a_mask_reset_zero: assert property (
        @(posedge ref_clk)
        !rst_n |=> load_mask == MASK_RESET)
        else $error("mask not cleared by reset");

    // masked channel holds on load fall
    a_masked_ch_hold: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (st_reg.mode == QDAC_RUN && !hrst_low && load_fall
            && st_reg.mask[0] && !frame_ok)
        |=> dac_code[0] == $past(dac_code[0]))
        else $error("masked channel followed load pin");

    a_write_defer: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (st_reg.mode == QDAC_RUN && !hrst_low && frame_ok
            && cmd == CMD_WR_INPUT && addr[1] && !load_low && !load_fall)
        |=> input_code[1] == $past(data)
            && dac_code[1] == $past(dac_code[1]))
        else $error("write-input with load high misbehaved");

    a_write_instant: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (st_reg.mode == QDAC_RUN && !hrst_low && frame_ok
            && cmd == CMD_WR_INPUT && addr[2] && load_low)
        |=> dac_code[2] == $past(data))
        else $error("write-input with load low missed dac");

    a_update_copy: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (st_reg.mode == QDAC_RUN && !hrst_low && frame_ok
            && cmd == CMD_UPDATE && addr[2])
        |=> dac_code[2] == $past(input_code[2])
            && input_code[2] == $past(input_code[2]))
        else $error("update command wrong");

    a_write_update: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (st_reg.mode == QDAC_RUN && !hrst_low && frame_ok
            && cmd == CMD_WR_UPDATE && addr[3])
        |=> dac_code[3] == $past(data) && input_code[3] == $past(data))
        else $error("write-and-update wrong");

    a_load_fall_copy: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (st_reg.mode == QDAC_RUN && !hrst_low && load_fall
            && !st_reg.mask[1] && !frame_ok)
        |=> dac_code[1] == $past(input_code[1]))
        else $error("load fall did not update channel");

    // cleared code held through hardware reset
    a_hwrst_block: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (mode == QDAC_HWRST && hrst_low) [*2]
        |-> dac_code[0] == clear_code($past(pins.reset_level_select)))
        else $error("outputs moved during hardware reset");

    a_init_wait: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (mode == QDAC_INIT && hrst_low) |=> mode == QDAC_INIT)
        else $error("initialised while reset pin low");

    // reset pin reaches hwrst one clock after the sync delay
    a_hwrst_enter: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (mode == QDAC_RUN && hrst_low) |=> mode == QDAC_HWRST)
        else $error("hardware reset not entered");

    a_sw_reset_code: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (st_reg.mode == QDAC_RUN && !hrst_low && frame_ok
            && cmd == CMD_SW_RESET)
        |=> dac_code[2] == clear_code($past(pins.reset_level_select))
            && load_mask == MASK_RESET)
        else $error("software reset did not restore code");

    a_powerup_code: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (mode == QDAC_INIT && !hrst_low)
        |=> mode == QDAC_RUN
            && dac_code[1] == clear_code($past(pins.reset_level_select)))
        else $error("power-up code wrong");

    a_release_hold: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (mode == QDAC_HWRST && !hrst_low)
        |=> mode == QDAC_RUN
            && dac_code[3] == clear_code($past(pins.reset_level_select)))
        else $error("code moved on reset release");

    // low load level overrides the mask
    a_low_mask_over: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (st_reg.mode == QDAC_RUN && !hrst_low && frame_ok
            && cmd == CMD_WR_INPUT && addr[0] && load_low
            && st_reg.mask[0])
        |=> dac_code[0] == $past(data))
        else $error("masked channel missed write with load low");

endmodule : qdac_update_ctrl

/* verif/qdac_host_model.sv */
// serial host model that sends whole 24-bit command frames
`timescale 1ns/1ps

module qdac_host_model
    import qdac_pkg::*;
(
    // clock
    input  wire logic              ref_clk,
    // serial lines toward the device
    output qdac_pkg::qdac_serial_s serial
);
    // sclk levels span 4 clocks so the 3-flop synchroniser sees each
    localparam int HALF = 4;

    initial begin
        serial.sclk   = 1'b0;
        serial.sdin   = 1'b0;
        serial.sync_n = 1'b1;
    end

    task automatic send(input logic [FRAME_BITS-1:0] word);
        @(negedge ref_clk);
        serial.sync_n = 1'b0;
        for (int i = FRAME_BITS - 1; i >= 0; i--) begin
            repeat (HALF) @(negedge ref_clk);
            serial.sclk = 1'b1;
            serial.sdin = word[i];
            repeat (HALF) @(negedge ref_clk);
            serial.sclk = 1'b0;
        end
        repeat (HALF) @(negedge ref_clk);
        serial.sync_n = 1'b1;
        // released data line, no pull: show the inverse, not stale data
        serial.sdin = ~serial.sdin;
        repeat (HALF) @(negedge ref_clk);
    endtask : send

endmodule : qdac_host_model

/* verif/test_quad_dac_load_update_control.sv */
// self-checking bench for the quad dac update control
`timescale 1ns/1ps

module test_quad_dac_load_update_control;
    import qdac_pkg::*;

    logic         ref_clk;
    logic         rst_n;
    qdac_serial_s serial;
    qdac_pins_s   pins;
    qdac_codes_t  dac_code;
    qdac_codes_t  input_code;
    logic [3:0]   load_mask;
    qdac_mode_e   mode;
    qdac_codes_t  exp_dac;
    qdac_codes_t  exp_in;
    logic [3:0]   exp_mask;
    int           miscompares;
    int           num_checks;

    initial ref_clk = 1'b0;
    always #50 ref_clk = ~ref_clk;

    qdac_update_ctrl dut_u (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .serial     (serial),
        .pins       (pins),
        .dac_code   (dac_code),
        .input_code (input_code),
        .load_mask  (load_mask),
        .mode       (mode)
    );

    qdac_host_model host_u (
        .ref_clk (ref_clk),
        .serial  (serial)
    );

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task automatic cmp(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("MISMATCH %s exp %h got %h", what, exp, got);
            miscompares++;
        end
    endtask : cmp

    task automatic chk_all;
        cmp("dac_code", exp_dac, dac_code);
        cmp("input_code", exp_in, input_code);
        cmp("load_mask", {60'h0, exp_mask}, {60'h0, load_mask});
    endtask : chk_all

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : wait_cyc

    // bounded wait; a hang ends the run as a failure
    task automatic wait_mode(input qdac_mode_e m);
        for (int i = 0; i < 40 && mode !== m; i++) @(negedge ref_clk);
        cmp("mode", {62'h0, m}, {62'h0, mode});
        if (mode !== m) end_sim();
    endtask : wait_mode

    // outputs settle 3 clocks after frame end; 6 leaves margin
    task automatic frame(input logic [3:0] cmd, input logic [3:0] sel,
                         input logic [15:0] code);
        host_u.send({cmd, sel, code});
        wait_cyc(6);
    endtask : frame

    task automatic set_load(input logic v);
        pins.load_strobe_n = v;
        wait_cyc(6);
    endtask : set_load

    task automatic t_power_up;
        // load pin toggles while reset is held and must be ignored
        for (int i = 0; i < 8; i++) begin
            pins.load_strobe_n = ~pins.load_strobe_n;
            wait_cyc(1);
        end
        rst_n = 1'b1;
        wait_mode(QDAC_RUN);
        exp_dac  = {4{CODE_MID}};
        exp_in   = {4{CODE_MID}};
        exp_mask = MASK_RESET;
        chk_all();
        $display("done power_up");
    endtask : t_power_up

    task automatic t_deferred;
        frame(CMD_WR_INPUT, 4'b0011, 16'h1234);
        exp_in[0] = 16'h1234;
        exp_in[1] = 16'h1234;
        chk_all();
        set_load(1'b0);
        exp_dac[0] = 16'h1234;
        exp_dac[1] = 16'h1234;
        chk_all();
        set_load(1'b1);
        chk_all();
        $display("done deferred");
    endtask : t_deferred

    task automatic t_mask;
        frame(CMD_LOAD_MASK, 4'hf, 16'hfff5);
        exp_mask = 4'h5;
        chk_all();
        frame(CMD_WR_INPUT, 4'hf, 16'habcd);
        exp_in = {4{16'habcd}};
        set_load(1'b0);
        exp_dac[1] = 16'habcd;
        exp_dac[3] = 16'habcd;
        chk_all();
        // load held low: a masked channel still follows the write
        frame(CMD_WR_INPUT, 4'b0101, 16'h5555);
        exp_in[0]  = 16'h5555;
        exp_in[2]  = 16'h5555;
        exp_dac[0] = 16'h5555;
        exp_dac[2] = 16'h5555;
        chk_all();
        set_load(1'b1);
        $display("done mask");
    endtask : t_mask

    task automatic t_update_cmds;
        frame(CMD_WR_INPUT, 4'b0100, 16'h7777);
        exp_in[2] = 16'h7777;
        chk_all();
        frame(CMD_UPDATE, 4'b0100, 16'h0000);
        exp_dac[2] = 16'h7777;
        chk_all();
        frame(CMD_WR_UPDATE, 4'b1000, 16'h4321);
        exp_in[3]  = 16'h4321;
        exp_dac[3] = 16'h4321;
        chk_all();
        $display("done update_cmds");
    endtask : t_update_cmds

    task automatic t_sw_reset;
        frame(CMD_SW_RESET, 4'h0, 16'h0000);
        exp_dac  = {4{CODE_MID}};
        exp_in   = {4{CODE_MID}};
        exp_mask = MASK_RESET;
        cmp("dac_code", exp_dac, dac_code);
        cmp("input_code", exp_in, input_code);
        cmp("load_mask", {60'h0, exp_mask}, {60'h0, load_mask});
        $display("done sw_reset");
    endtask : t_sw_reset

    task automatic t_hw_reset;
        pins.reset_level_select = 1'b0;
        // pin low well past the minimum
        pins.hw_reset_n = 1'b0;
        wait_cyc(5);
        exp_dac = {4{CODE_ZERO}};
        exp_in  = {4{CODE_ZERO}};
        cmp("mode", {62'h0, QDAC_HWRST}, {62'h0, mode});
        chk_all();
        frame(CMD_WR_UPDATE, 4'hf, 16'h1111);
        set_load(1'b0);
        set_load(1'b1);
        chk_all();
        pins.hw_reset_n = 1'b1;
        wait_mode(QDAC_RUN);
        wait_cyc(20);
        chk_all();
        $display("done hw_reset");
    endtask : t_hw_reset

    task automatic t_init_hold;
        rst_n           = 1'b0;
        pins.hw_reset_n = 1'b0;
        wait_cyc(8);
        rst_n = 1'b1;
        wait_cyc(10);
        cmp("mode", {62'h0, QDAC_INIT}, {62'h0, mode});
        pins.reset_level_select = 1'b1;
        pins.hw_reset_n         = 1'b1;
        wait_mode(QDAC_RUN);
        exp_dac = {4{CODE_MID}};
        exp_in  = {4{CODE_MID}};
        chk_all();
        $display("done init_hold");
    endtask : t_init_hold

    initial begin
        miscompares = 0;
        num_checks  = 0;
        rst_n       = 1'b0;
        pins        = '{load_strobe_n: 1'b1, hw_reset_n: 1'b1,
                        reset_level_select: 1'b1};
        exp_mask    = MASK_RESET;
        @(negedge ref_clk);
        t_power_up();
        t_deferred();
        t_mask();
        t_update_cmds();
        t_sw_reset();
        t_hw_reset();
        t_init_hold();
        end_sim();
    end

endmodule : test_quad_dac_load_update_control
